// File: hdl/dpm_pkg.sv
// Constants, types and state codes for the port-side host of a two-port mailbox memory.
// Assumes one host per memory port, a 25 MHz clock and device pins sampled as synchronous inputs.
package dpm_pkg;

  localparam int ADDR_W = 13;                        // Word address width of the memory
  localparam int DATA_W = 16;                        // Data width of one port
  localparam int SEM_ADDR_W = 3;                     // Flag space uses only the low address bits
  localparam logic [12:0] LEFT_MAILBOX = 13'h1ffe;   // Mailbox that raises the left flag
  localparam logic [12:0] RIGHT_MAILBOX = 13'h1fff;  // Mailbox that raises the right flag
  localparam logic [15:0] SEM_CLAIM_WORD = 16'h0000; // Zero on bit 0 requests a token
  localparam logic [15:0] SEM_FREE_WORD = 16'h0001;  // One on bit 0 releases a token

  localparam int CLK_PERIOD_NS = 40;                 // mclk_i period
  localparam int ACCESS_NS = 55;                     // Least strobe width for a full access
  localparam int SETTLE_NS = 20;                     // Least time for the collision result to settle
  localparam int ACCESS_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_CYC = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RETRY_MAX = 16;                     // Settle retries before a write gives up

  // User commands
  typedef enum logic [2:0] {
    DPM_OP_READ = 3'h0,     // Plain memory read
    DPM_OP_WRITE = 3'h1,    // Plain memory write
    DPM_OP_POST = 3'h2,     // Write the partner's mailbox
    DPM_OP_FETCH = 3'h3,    // Read own mailbox, clearing own flag
    DPM_OP_SEM_TAKE = 3'h4, // Claim a semaphore then read it back
    DPM_OP_SEM_GIVE = 3'h5  // Release a semaphore
  } dpm_op_e;

  // Sequencer states, one-hot
  typedef enum logic [3:0] {
    DPM_ST_IDLE = 4'b0001,
    DPM_ST_SETUP = 4'b0010,
    DPM_ST_STROBE = 4'b0100,
    DPM_ST_GAP = 4'b1000
  } dpm_state_e;

  // One command from the user side
  typedef struct packed {
    dpm_op_e op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } dpm_cmd_s;

  // Control pins driven toward the memory port, all active low except the address
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic port_select_n;
    logic flag_space_select_n;
    logic write_strobe_n;
    logic output_enable_n;
  } dpm_pins_s;

  // Answer to the user side
  typedef struct packed {
    logic [DATA_W-1:0] rdata;
    logic collided;
    logic grant;
    logic error;
  } dpm_rsp_s;

endpackage : dpm_pkg

// File: hdl/dpm_timer.sv
// Down counter that times setup and strobe phases of the port host.
// Assumes the loader holds load for one cycle; done stays high at zero.
`timescale 1ns/1ps
`default_nettype none
module dpm_timer #(
  parameter int WIDTH = 8
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic load_i,
  input wire logic [WIDTH-1:0] load_val_i,
  output logic done_o
);

  logic [WIDTH-1:0] count;      // Cycles left in the current phase
  logic [WIDTH-1:0] next_count; // Count for the next edge

  // Load wins over counting so that a phase can restart at once
  always_comb begin
    next_count = count;
    if (load_i) begin
      next_count = load_val_i;
    end else if (count != '0) begin
      next_count = count - WIDTH'(1);
    end
  end

  // Register only
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  assign done_o = (count == '0);

endmodule : dpm_timer
`default_nettype wire

// File: hdl/dpm_port_host.sv
// Host sequencer for one port of a two-port mailbox memory: memory, mailbox and semaphore accesses.
// Assumes device pins are synchronous to mclk_i and the data bus is resolved outside from data_oe_o.
`timescale 1ns/1ps
`default_nettype none
module dpm_port_host
  import dpm_pkg::*;
#(
  parameter bit LEFT_PORT = 1'b1, // Selects which mailbox is own and which is partner's
  parameter int TIMER_W = 8       // Width of the phase timer
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic cmd_valid_i,
  input wire dpm_cmd_s cmd_i,
  output logic cmd_ready_o,
  output logic done_o,
  output dpm_rsp_s rsp_o,
  output dpm_pins_s pins_o,
  output logic [DATA_W-1:0] data_o,
  output logic data_oe_o,
  input wire logic [DATA_W-1:0] data_i,
  input wire logic collision_flag_n_i,
  input wire logic mailbox_flag_n_i,
  output logic mailbox_pending_o
);

  // Mailbox choice per side
  localparam logic [ADDR_W-1:0] OWN_BOX = LEFT_PORT ? LEFT_MAILBOX : RIGHT_MAILBOX;
  localparam logic [ADDR_W-1:0] PARTNER_BOX = LEFT_PORT ? RIGHT_MAILBOX : LEFT_MAILBOX;
  localparam logic [TIMER_W-1:0] SETTLE_LOAD = TIMER_W'(SETTLE_CYC - 1);
  localparam logic [TIMER_W-1:0] ACCESS_LOAD = TIMER_W'(ACCESS_CYC - 1);
  localparam int RETRY_W = $clog2(RETRY_MAX + 1);

  dpm_state_e state, next_state;           // Sequencer state
  dpm_cmd_s cmd, next_cmd;                 // Command being served
  dpm_pins_s pins, next_pins;              // Registered control pins
  dpm_rsp_s rsp, next_rsp;                 // Registered answer
  logic [DATA_W-1:0] wdata, next_wdata;    // Registered bus data
  logic data_oe, next_data_oe;             // Registered bus drive enable
  logic is_write, next_is_write;           // Current pass writes
  logic is_sem, next_is_sem;               // Current pass targets flag space
  logic phase, next_phase;                 // Second pass of a semaphore claim
  logic ready, next_ready;                 // Registered ready
  logic done, next_done;                   // One-cycle completion pulse
  logic [RETRY_W-1:0] retries, next_retries; // Settle retries of a blocked write
  logic mbox, next_mbox;                   // Registered own mailbox flag
  logic tmr_load;                          // Restart the phase timer
  logic [TIMER_W-1:0] tmr_val;             // Timer reload value
  logic tmr_done;                          // Current phase elapsed

  dpm_timer #(
    .WIDTH(TIMER_W)
  ) u_timer (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .load_i(tmr_load),
    .load_val_i(tmr_val),
    .done_o(tmr_done)
  );

  // Own flag is shown as an active-high level; pin is active low
  always_comb begin
    next_mbox = !mailbox_flag_n_i;
  end

  // Sequencer: every pin change happens on a state edge so that outputs stay registered
  always_comb begin
    next_state = state;
    next_cmd = cmd;
    next_pins = pins;
    next_rsp = rsp;
    next_wdata = wdata;
    next_data_oe = data_oe;
    next_is_write = is_write;
    next_is_sem = is_sem;
    next_phase = phase;
    next_done = 1'b0;
    next_retries = retries;
    tmr_load = 1'b0;
    tmr_val = SETTLE_LOAD;
    case (state)
      DPM_ST_IDLE: begin
        if (cmd_valid_i) begin
          next_cmd = cmd_i;
          next_rsp = '0;
          next_phase = 1'b0;
          next_retries = '0;
          next_is_sem = (cmd_i.op == DPM_OP_SEM_TAKE) || (cmd_i.op == DPM_OP_SEM_GIVE);
          next_is_write = (cmd_i.op != DPM_OP_READ) && (cmd_i.op != DPM_OP_FETCH);
          next_wdata = cmd_i.wdata;
          next_pins.addr = cmd_i.addr; // Plain accesses may reach the mailbox words as storage
          case (cmd_i.op)
            DPM_OP_POST: begin
              next_pins.addr = PARTNER_BOX; // Partner's flag rises on this write
            end
            DPM_OP_FETCH: begin
              next_pins.addr = OWN_BOX; // Reading own box with enable low clears own flag
            end
            DPM_OP_SEM_TAKE: begin
              next_pins.addr = {{(ADDR_W-SEM_ADDR_W){1'b0}}, cmd_i.addr[SEM_ADDR_W-1:0]};
              next_wdata = SEM_CLAIM_WORD; // Write first, read after, to avoid contention
            end
            DPM_OP_SEM_GIVE: begin
              next_pins.addr = {{(ADDR_W-SEM_ADDR_W){1'b0}}, cmd_i.addr[SEM_ADDR_W-1:0]};
              next_wdata = SEM_FREE_WORD; // Owner's one frees or hands over the token
            end
            default: begin
              next_pins.addr = cmd_i.addr;
            end
          endcase
          // Only one space is selected at a time; both high is standby
          next_pins.port_select_n = next_is_sem;
          next_pins.flag_space_select_n = !next_is_sem;
          tmr_load = 1'b1;
          tmr_val = SETTLE_LOAD;
          next_state = DPM_ST_SETUP;
        end
      end
      DPM_ST_SETUP: begin
        // Address and select stand while the collision result settles
        if (tmr_done) begin
          if (is_write && !is_sem && !collision_flag_n_i) begin
            // Strobing now would be gated away, so wait; a held-low input gives up with an error after RETRY_MAX retries
            if (retries == RETRY_W'(RETRY_MAX)) begin
              next_rsp.error = 1'b1;
              next_rsp.collided = 1'b1;
              next_pins.port_select_n = 1'b1;
              next_pins.flag_space_select_n = 1'b1;
              next_state = DPM_ST_GAP;
            end else begin
              next_retries = retries + RETRY_W'(1);
              tmr_load = 1'b1;
              tmr_val = SETTLE_LOAD;
            end
          end else begin
            // Collision input high lets the write go ahead as normal
            next_pins.write_strobe_n = !is_write;
            next_pins.output_enable_n = is_write;
            next_data_oe = is_write;
            tmr_load = 1'b1;
            tmr_val = ACCESS_LOAD; // Fixed length: flag accesses add no wait
            next_state = DPM_ST_STROBE;
          end
        end
      end
      DPM_ST_STROBE: begin
        if (tmr_done) begin
          if (!is_write) begin
            next_rsp.rdata = data_i;
            next_rsp.grant = is_sem && !data_i[0]; // Zero read back means this side owns it
          end
          // A read under collision is served but reported to the user
          next_rsp.collided = rsp.collided || !collision_flag_n_i;
          next_pins.write_strobe_n = 1'b1;
          next_pins.output_enable_n = 1'b1;
          next_pins.port_select_n = 1'b1;
          next_pins.flag_space_select_n = 1'b1;
          next_data_oe = 1'b0;
          next_state = DPM_ST_GAP;
        end
      end
      DPM_ST_GAP: begin
        // Selects dropped for a cycle so the next flag read latches a fresh value
        if (cmd.op == DPM_OP_SEM_TAKE && !phase && !rsp.error) begin
          next_phase = 1'b1;
          next_is_write = 1'b0;
          next_pins.flag_space_select_n = 1'b0;
          tmr_load = 1'b1;
          tmr_val = SETTLE_LOAD;
          next_state = DPM_ST_SETUP;
        end else begin
          next_done = 1'b1;
          next_state = DPM_ST_IDLE;
        end
      end
      default: begin
        next_state = DPM_ST_IDLE;
        next_pins = '{addr: '0, default: 1'b1};
        next_data_oe = 1'b0;
      end
    endcase
    next_ready = (next_state == DPM_ST_IDLE);
  end

  // Register only
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= DPM_ST_IDLE;
      cmd <= '0;
      pins <= '{addr: '0, default: 1'b1};
      rsp <= '0;
      wdata <= '0;
      data_oe <= 1'b0;
      is_write <= 1'b0;
      is_sem <= 1'b0;
      phase <= 1'b0;
      ready <= 1'b0;
      done <= 1'b0;
      retries <= '0;
      mbox <= 1'b0;
    end else begin
      state <= next_state;
      cmd <= next_cmd;
      pins <= next_pins;
      rsp <= next_rsp;
      wdata <= next_wdata;
      data_oe <= next_data_oe;
      is_write <= next_is_write;
      is_sem <= next_is_sem;
      phase <= next_phase;
      ready <= next_ready;
      done <= next_done;
      retries <= next_retries;
      mbox <= next_mbox;
    end
  end

  // Every output is a flop; the collision input is the array's combined, single-master result
  assign cmd_ready_o = ready;
  assign done_o = done;
  assign rsp_o = rsp;
  assign pins_o = pins;
  assign data_o = wdata;
  assign data_oe_o = data_oe;
  assign mailbox_pending_o = mbox;

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n_i);

  sequence s_strobe_pulse;
    (!pins.write_strobe_n)[*2] ##1 pins.write_strobe_n;
  endsequence

  sequence s_settled_clear;
    $past(collision_flag_n_i) && !pins.write_strobe_n;
  endsequence

  a_standby_exclusive: assert property (!(!pins.port_select_n && !pins.flag_space_select_n))
    else $error("both selects low");
  a_strobe_settled: assert property ($fell(pins.write_strobe_n) && !pins.port_select_n |-> s_settled_clear)
    else $error("write strobe began under collision");
  a_strobe_width: assert property ($fell(pins.write_strobe_n) |-> s_strobe_pulse)
    else $error("strobe width wrong");
  a_flag_addr_low: assert property (!pins.flag_space_select_n |-> pins.addr[ADDR_W-1:SEM_ADDR_W] == '0)
    else $error("flag address has high bits");
  a_post_target: assert property (!pins.write_strobe_n && cmd.op == DPM_OP_POST |-> pins.addr == PARTNER_BOX)
    else $error("post to wrong mailbox");
  a_fetch_clears: assert property (!pins.output_enable_n && cmd.op == DPM_OP_FETCH
    |-> pins.addr == OWN_BOX && !pins.port_select_n)
    else $error("fetch misses own mailbox");
  a_take_reread: assert property (cmd.op == DPM_OP_SEM_TAKE && $rose(pins.write_strobe_n)
    |-> pins.flag_space_select_n ##1 !pins.flag_space_select_n)
    else $error("claim not followed by fresh read");
  a_claim_zero: assert property (!pins.write_strobe_n && cmd.op == DPM_OP_SEM_TAKE |-> data_oe && !wdata[0])
    else $error("claim does not write zero");
  // Ready rises with done; a new take may follow at once, so ready is not checked a cycle later
  a_done_pulse: assert property (done |-> ready ##1 !done)
    else $error("done not a single pulse");
  // Giving up is only legal when the last setup check still saw the collision low
  a_block_bounded: assert property ($rose(rsp.error)
    |-> !$past(collision_flag_n_i) && pins.write_strobe_n)
    else $error("write given up without collision");

endmodule : dpm_port_host
`default_nettype wire

// File: testbench/dpm_dev_model.sv
// Behavioural model of the two-port memory seen from its left port, with right-port tasks.
// Assumes host pins are registered on mclk_i; the bench plays the right processor through the tasks.
`timescale 1ns/1ps
`default_nettype none
module dpm_dev_model
  import dpm_pkg::*;
(
  input wire logic mclk_i,
  input wire dpm_pins_s pins_i,
  input wire logic [DATA_W-1:0] wdata_i, // Bus level as resolved by the bench
  input wire logic busy_req_i,           // Bench asks for a clash with the right port
  output logic [DATA_W-1:0] rdata_o,
  output logic collision_flag_n_o,
  output logic mailbox_flag_n_o
);
  logic [DATA_W-1:0] mem [0:8191]; // Storage array
  logic right_flag_n = 1'b1;       // Right mailbox flag, active low
  logic left_flag_n = 1'b1;        // Left mailbox flag, active low
  logic [7:0] own [2] = '{8'h00, 8'h00}; // Token held, index 0 is left; apart from the array
  logic [7:0] req [2] = '{8'h00, 8'h00}; // Pending requests per side
  logic sem_hold = 1'b0;           // Read latch closed
  logic sem_val = 1'b1;            // Latched flag value
  logic [DATA_W-1:0] last = '0;    // Last bus value, inverted when released
  wire sel_mem = !pins_i.port_select_n;
  wire sel_sem = !pins_i.flag_space_select_n;
  wire rd_en = !pins_i.output_enable_n;

  // Clash only toward the left port, so both sides are never flagged together
  // Master role: the pin is the arbiter's output, whatever the access kind
  assign collision_flag_n_o = !busy_req_i;
  assign mailbox_flag_n_o = left_flag_n;

  // Token update for either side; a zero claims, a one releases or passes on
  task automatic sem_wr(input bit side, input logic [2:0] i, input logic b);
    if (!b) begin
      if (!own[!side][i]) own[side][i] = 1'b1; // Free or already ours
      else req[side][i] = 1'b1;                 // Held by the other side
    end else begin
      req[side][i] = 1'b0;
      if (own[side][i]) begin // Only the owner changes the flag
        own[side][i] = 1'b0;
        if (req[!side][i]) begin
          own[!side][i] = 1'b1;
          req[!side][i] = 1'b0;
        end
      end
    end
  endtask : sem_wr

  // Left port accesses; nothing happens while both selects are high
  always @(posedge mclk_i) begin
    last <= rdata_o;
    if (sel_mem && !pins_i.write_strobe_n && collision_flag_n_o) begin // Gated while clashing
      mem[pins_i.addr] <= wdata_i;
      if (pins_i.addr == RIGHT_MAILBOX) right_flag_n <= 1'b0;
    end
    if (sel_mem && rd_en && pins_i.addr == LEFT_MAILBOX) left_flag_n <= 1'b1;
    if (sel_sem && !pins_i.write_strobe_n) sem_wr(1'b0, pins_i.addr[2:0], wdata_i[0]); // Low bits only
    if (sel_sem && rd_en) begin
      if (!sem_hold) sem_val <= !own[0][pins_i.addr[2:0]]; // Held until a select drops
      sem_hold <= 1'b1;
    end else begin
      sem_hold <= 1'b0;
    end
  end

  // Answers at once, no wait states; a released bus shows a changing pattern
  always_comb begin
    if (sel_mem && rd_en) rdata_o = mem[pins_i.addr];
    else if (sel_sem && rd_en) rdata_o = {DATA_W{sem_hold ? sem_val : !own[0][pins_i.addr[2:0]]}};
    else rdata_o = ~last;
  end

  // Right-port write; the left mailbox raises the left flag
  task automatic right_write(input logic [12:0] a, input logic [15:0] d);
    mem[a] = d;
    if (a == LEFT_MAILBOX) left_flag_n = 1'b0;
  endtask : right_write

  // Right-port read; its own mailbox clears its flag
  task automatic right_read(input logic [12:0] a, output logic [15:0] d);
    d = mem[a];
    if (a == RIGHT_MAILBOX) right_flag_n = 1'b1;
  endtask : right_read

  // Right-port flag write followed by its read-back
  task automatic right_sem(input logic [2:0] i, input logic b, output logic rd);
    sem_wr(1'b1, i, b);
    rd = !own[1][i];
  endtask : right_sem
endmodule : dpm_dev_model
`default_nettype wire

// File: testbench/tb_dpm_port_host.sv
// Self-checking bench for the left-port host against the memory model.
// Assumes the model stands in for the device and the bench plays the right processor.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; \
  $display("mismatch %s expected %0h seen %0h", nm, e, g); end end
module tb_dpm_port_host
  import dpm_pkg::*;
;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic cmd_valid = 1'b0;
  logic busy = 1'b0;    // High asks the model for a clash
  dpm_cmd_s cmd = '0;
  logic cmd_ready, done, data_oe, pending, coll_n, mbox_n;
  dpm_rsp_s rsp;
  dpm_pins_s pins;
  logic [15:0] hdata, ddata;
  int n_mismatch = 0;
  int n_compared = 0;
  int cycles = 0;
  // An undriven bus would still carry the host's value, so model it inverted
  wire logic [15:0] bus = data_oe ? hdata : ~hdata;

  always #20 mclk_i = ~mclk_i;

  dpm_port_host #(.LEFT_PORT(1'b1), .TIMER_W(8)) uut (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .cmd_valid_i(cmd_valid), .cmd_i(cmd), .cmd_ready_o(cmd_ready), .done_o(done), .rsp_o(rsp),
    .pins_o(pins), .data_o(hdata), .data_oe_o(data_oe), .data_i(ddata), .collision_flag_n_i(coll_n),
    .mailbox_flag_n_i(mbox_n), .mailbox_pending_o(pending));
  dpm_dev_model model (.mclk_i(mclk_i), .pins_i(pins), .wdata_i(bus), .busy_req_i(busy),
    .rdata_o(ddata), .collision_flag_n_o(coll_n), .mailbox_flag_n_o(mbox_n));

  // Verdict and end of run
  task automatic end_of_test();
    if (n_mismatch == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_of_test

  // Hang guard, far above the few hundred cycles the tests need
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      end_of_test();
    end
  end

  // One command: wait for ready, present it for the take edge, count cycles to done
  task automatic run(input dpm_op_e op, input logic [12:0] a, input logic [15:0] d, output int cyc);
    cyc = 0;
    while (cmd_ready !== 1'b1) @(posedge mclk_i) #1;
    @(posedge mclk_i);
    cmd_valid <= 1'b1;
    cmd <= '{op, a, d};
    @(posedge mclk_i);
    cmd_valid <= 1'b0;
    while (done !== 1'b1 && cyc < 60) begin
      @(posedge mclk_i);
      #1;
      cyc++;
    end
    // A command that never finishes counts as a mismatch and ends the run
    if (done !== 1'b1) begin
      n_mismatch++;
      end_of_test();
    end
  endtask : run

  // Plain write then read, back to back; done is registered after settle, access and gap
  task automatic t_mem();
    int c;
    run(DPM_OP_WRITE, 13'h0123, 16'habcd, c);
    `CHK("write cycles", SETTLE_CYC + ACCESS_CYC + 1, c)
    run(DPM_OP_READ, 13'h0123, 16'h0000, c);
    `CHK("read data", 16'habcd, rsp.rdata)
    `CHK("read cycles", SETTLE_CYC + ACCESS_CYC + 1, c)
  endtask : t_mem

  // Mailboxes in both directions
  task automatic t_mail();
    int c;
    logic [15:0] v;
    run(DPM_OP_POST, 13'h0000, 16'h5a5a, c);
    `CHK("right flag set", 1'b0, model.right_flag_n)
    model.right_read(RIGHT_MAILBOX, v);
    `CHK("right box data", 16'h5a5a, v)
    `CHK("right flag clear", 1'b1, model.right_flag_n)
    model.right_write(LEFT_MAILBOX, 16'h1234);
    repeat (2) @(posedge mclk_i);
    #1;
    `CHK("pending set", 1'b1, pending)
    run(DPM_OP_FETCH, 13'h0000, 16'h0000, c);
    `CHK("fetch data", 16'h1234, rsp.rdata)
    repeat (2) @(posedge mclk_i);
    #1;
    `CHK("pending clear", 1'b0, pending)
  endtask : t_mail

  // Clash that clears mid-write, a clash that never clears, and a read under clash
  task automatic t_coll();
    int c;
    @(posedge mclk_i);
    busy <= 1'b1;
    fork
      run(DPM_OP_WRITE, 13'h0040, 16'h0f0f, c);
      begin
        repeat (4) @(posedge mclk_i);
        busy <= 1'b0;
      end
    join
    `CHK("retried write", 16'h0f0f, model.mem[13'h0040])
    `CHK("write held back", 1'b1, c > SETTLE_CYC + ACCESS_CYC + 1)
    @(posedge mclk_i);
    busy <= 1'b1;
    run(DPM_OP_WRITE, 13'h0040, 16'hdead, c);
    `CHK("blocked write", 16'h0f0f, model.mem[13'h0040])
    `CHK("blocked status", 2'b11, {rsp.error, rsp.collided})
    run(DPM_OP_READ, 13'h0040, 16'h0000, c);
    `CHK("read under clash", 17'h1_0f0f, {rsp.collided, rsp.rdata})
    @(posedge mclk_i);
    busy <= 1'b0;
  endtask : t_coll

  // Token claims against the right side, then every flag once
  task automatic t_sem();
    int c;
    logic b;
    run(DPM_OP_SEM_TAKE, 13'h1ff9, 16'h0000, c);
    `CHK("take free", 1'b1, rsp.grant)
    model.right_sem(3'h1, 1'b0, b);
    `CHK("right refused", 1'b1, b)
    run(DPM_OP_SEM_GIVE, 13'h0001, 16'h0000, c);
    `CHK("token passed", 1'b1, model.own[1][1])
    run(DPM_OP_SEM_TAKE, 13'h0009, 16'h0000, c);
    `CHK("take held", 1'b0, rsp.grant)
    model.right_sem(3'h1, 1'b1, b);
    run(DPM_OP_SEM_TAKE, 13'h0001, 16'h0000, c);
    `CHK("take after pass", 1'b1, rsp.grant)
    for (int i = 0; i < 8; i++) begin
      run(DPM_OP_SEM_GIVE, {10'h3ff, 3'(i)}, 16'h0000, c);
      run(DPM_OP_SEM_TAKE, {10'h3ff, 3'(i)}, 16'h0000, c);
      `CHK("each flag", 1'b1, rsp.grant)
    end
    `CHK("memory kept", 16'h0f0f, model.mem[13'h0040])
  endtask : t_sem

  // Reset held four cycles, idle pins checked inside it, then the scenarios
  initial begin
    repeat (3) @(posedge mclk_i);
    #1;
    `CHK("reset pins", 5'h1f, {pins[3:0], ~cmd_ready})
    @(posedge mclk_i);
    rst_n_i <= 1'b1;
    t_mem();
    t_mail();
    t_coll();
    t_sem();
    end_of_test();
  end
endmodule : tb_dpm_port_host
`undef CHK
`default_nettype wire
